// ---- hdl/gcs_cfg.svh ----
/*
 * Offsets, field positions and reset values of the global control and
 * status registers. Assumes a 16-bit register address from the serial
 * host port decoder.
 */
`ifndef GCS_CFG_SVH
`define GCS_CFG_SVH

`define GCS_ADDR_W 16
`define GCS_CFG_BASE 16'h8000
`define GCS_STATUS_ADDR 16'h800E
`define GCS_CONTROL_ADDR 16'h800F

`define GCS_CTL_RX_EN_BIT 7
`define GCS_CTL_TX_EN_BIT 6
`define GCS_CTL_FLIP_BIT 3
`define GCS_CTL_RESET 8'h00

`define GCS_ST_READY_BIT 7
`define GCS_ST_ACTIVE_BIT 6
`define GCS_ST_SAFE_BIT 5
`define GCS_ST_RAM_CHECK_BUSY_BIT 4
`define GCS_ST_EEPROM_PROGRAM_ACTIVE_BIT 3
`define GCS_ST_AUTOLOAD_BIT 2
`define GCS_ST_RESET 8'h00

`define GCS_RX_CHANNELS 8
`define GCS_TX_CHANNELS 4
`define GCS_LABEL_W 8

`endif

// ---- hdl/gcs_pkg.sv ----
/*
 * Types shared by the global control/status block.
 * Assumes gcs_cfg.svh supplies the numeric constants.
 */
package gcs_pkg;
  typedef logic [7:0] gcs_byte_t;
  typedef logic [15:0] gcs_addr_t;
  typedef logic [7:0] gcs_label_t;

  typedef struct packed {
    logic receive_global_enable;
    logic transmit_global_enable;
    logic [1:0] must_be_zero;
    logic label_bit_reverse;
    logic [2:0] spare;
  } gcs_ctrl_s;
endpackage

// ---- hdl/gcs_stat_if.sv ----
/*
 * Operating-state flags passed from the status tracker to the register bank.
 * Assumes one clock domain; all members are registered at the producer.
 */
`timescale 1ns/1ps
interface gcs_stat_if;
  logic ready;
  logic active;
  logic safe;
  logic ram_check_busy;
  logic eeprom_program_active;
  logic config_autoload_active;

  modport prod (
    output ready,
    output active,
    output safe,
    output ram_check_busy,
    output eeprom_program_active,
    output config_autoload_active
  );
  modport cons (
    input ready,
    input active,
    input safe,
    input ram_check_busy,
    input eeprom_program_active,
    input config_autoload_active
  );
endinterface

// ---- hdl/gcs_status.sv ----
/*
 * Tracks the device operating state from engine activity inputs.
 * Assumes all inputs are synchronous to clk and held as levels.
 */
`timescale 1ns/1ps
module gcs_status (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic core_ready,
  input wire logic bist_fail,
  input wire logic config_autoload_active_fail,
  input wire logic ram_check_run,
  input wire logic ram_clear_run,
  input wire logic eeprom_eeprom_program_active_run,
  input wire logic autoload_run,
  gcs_stat_if.prod st
);
  import gcs_pkg::*;

  logic ready_ff;
  logic active_ff;
  logic safe_ff;
  logic ram_busy_ff;
  logic eeprom_program_active_ff;
  logic autoload_ff;
  logic nxt_ready;
  logic nxt_active;

  // Programming cycle forces ready low until it ends
  assign nxt_ready = core_ready & ~eeprom_eeprom_program_active_run; // R13
  // Not active while loading, checking or in safe mode
  assign nxt_active = run & nxt_ready & ~safe_ff & ~(bist_fail | config_autoload_active_fail)
    & ~autoload_run & ~ram_check_run & ~ram_clear_run; // R9

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_ff <= 1'b0;
    end else begin
      ready_ff <= nxt_ready; // R8
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_ff <= 1'b0;
    end else begin
      active_ff <= nxt_active; // R9
    end
  end

  // Safe mode is left only through reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      safe_ff <= 1'b0;
    end else if (bist_fail | config_autoload_active_fail) begin
      safe_ff <= 1'b1; // R10
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ram_busy_ff <= 1'b0;
      eeprom_program_active_ff <= 1'b0;
      autoload_ff <= 1'b0;
    end else begin
      ram_busy_ff <= ram_check_run | ram_clear_run; // R11
      eeprom_program_active_ff <= eeprom_eeprom_program_active_run; // R12
      autoload_ff <= autoload_run; // R14
    end
  end

  assign st.ready = ready_ff;
  assign st.active = active_ff;
  assign st.safe = safe_ff;
  assign st.ram_check_busy = ram_busy_ff;
  assign st.eeprom_program_active = eeprom_program_active_ff;
  assign st.config_autoload_active = autoload_ff;
endmodule // gcs_status

// ---- hdl/gcs_regs.sv ----
/*
 * Global control and status register bank with channel gating and label
 * bit-order reversal. Assumes the serial host port decoder presents one-cycle
 * read and write strobes with a 16-bit address, synchronous to clk.
 */
// Contract
// R1: The configuration registers live in the space starting at 0x8000 and alone set up the device.
// R2: Control bit 7 is the receive global enable; no receive channel accepts words unless it is one.
// R3: With the receive global enable zero every receive bus is ignored, whatever channel enables say.
// R4: Control bit 6 is the transmit global enable; no transmit channel sends unless it is one.
// R5: With the transmit global enable zero no data is sent and all four schedulers are held in reset.
// R6: Control bit 3 reverses the order of the eight label bits on both receive and transmit paths.
// R7: The status register at 0x800E can be read at any time in any state.
// R8: Status bit 7 mirrors the ready pin, high when host commands can be served.
// R9: Status bit 6 is one once run is asserted and the device is in normal operation.
// R10: Status bit 5 sets on entry to safe mode after a self-test or autoload failure.
// R11: Status bit 4 is one while the RAM check and RAM clearing run.
// R12: Status bit 3 is one during an external EEPROM programming cycle.
// R13: During EEPROM programming the ready pin and status bit 7 stay low until it completes.
// R14: Status bit 2 is one while the device loads its setup from the autoload EEPROM.
// R15: The host writes receive channel control only while idle (run low, ready high).
// R16: The host writes zero to control bits 5 and 4 and should write zero to bits 2 to 0.
// R17: The status register is read-only, ignores writes, and bits 1 and 0 read zero.
`timescale 1ns/1ps
`include "gcs_cfg.svh"
module gcs_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire gcs_pkg::gcs_addr_t reg_addr,
  input wire logic reg_wr,
  input wire gcs_pkg::gcs_byte_t reg_wdata,
  input wire logic reg_rd,
  output gcs_pkg::gcs_byte_t reg_rdata,
  output logic reg_rvalid,
  output logic reg_hit,
  input wire logic run,
  input wire logic core_ready,
  input wire logic bist_fail,
  input wire logic config_autoload_active_fail,
  input wire logic ram_check_run,
  input wire logic ram_clear_run,
  input wire logic eeprom_eeprom_program_active_run,
  input wire logic autoload_run,
  output logic ready,
  output logic host_idle,
  output logic receive_global_enable,
  output logic transmit_global_enable,
  output logic label_bit_reverse,
  input wire logic [7:0] rx_chan_enable,
  output logic [7:0] rx_chan_accept,
  input wire logic [3:0] tx_chan_enable,
  output logic [3:0] tx_chan_send,
  output logic [3:0] tx_sched_reset,
  input wire gcs_pkg::gcs_label_t rx_label_in,
  input wire logic rx_label_valid,
  output gcs_pkg::gcs_label_t rx_label_out,
  output logic rx_label_out_valid,
  input wire gcs_pkg::gcs_label_t tx_label_in,
  input wire logic tx_label_valid,
  output gcs_pkg::gcs_label_t tx_label_out,
  output logic tx_label_out_valid
);
  import gcs_pkg::*;

  gcs_stat_if st_bus ();

  gcs_ctrl_s ctrl_ff;
  gcs_byte_t rdata_ff;
  logic rvalid_ff;
  logic hit_ff;
  logic idle_ff;
  logic [7:0] rx_accept_ff;
  logic [3:0] tx_send_ff;
  logic [3:0] tx_rst_ff;
  gcs_label_t rx_lbl_ff;
  gcs_label_t tx_lbl_ff;
  logic rx_lbl_v_ff;
  logic tx_lbl_v_ff;
  gcs_label_t rx_rev;
  gcs_label_t tx_rev;
  gcs_label_t nxt_rx_lbl;
  gcs_label_t nxt_tx_lbl;
  gcs_byte_t status_word;
  gcs_byte_t nxt_rdata;
  logic nxt_hit;
  logic ctl_sel;
  logic st_sel;

  gcs_status u_status (
    .clk(clk),
    .rst_n(rst_n),
    .run(run),
    .core_ready(core_ready),
    .bist_fail(bist_fail),
    .config_autoload_active_fail(config_autoload_active_fail),
    .ram_check_run(ram_check_run),
    .ram_clear_run(ram_clear_run),
    .eeprom_eeprom_program_active_run(eeprom_eeprom_program_active_run),
    .autoload_run(autoload_run),
    .st(st_bus.prod)
  );

  // Address decode inside the configuration space
  assign ctl_sel = (reg_addr == `GCS_CONTROL_ADDR); // R1
  assign st_sel = (reg_addr == `GCS_STATUS_ADDR); // R7

  // Status assembly; unused bits tied low
  always_comb begin
    status_word = `GCS_ST_RESET; // R17
    status_word[`GCS_ST_READY_BIT] = st_bus.ready; // R8
    status_word[`GCS_ST_ACTIVE_BIT] = st_bus.active; // R9
    status_word[`GCS_ST_SAFE_BIT] = st_bus.safe; // R10
    status_word[`GCS_ST_RAM_CHECK_BUSY_BIT] = st_bus.ram_check_busy; // R11
    status_word[`GCS_ST_EEPROM_PROGRAM_ACTIVE_BIT] = st_bus.eeprom_program_active; // R12
    status_word[`GCS_ST_AUTOLOAD_BIT] = st_bus.config_autoload_active; // R14
  end

  // Control register: all eight bits store what the host writes;
  // reserved bits are kept so software reads back what it wrote
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= `GCS_CTL_RESET;
    end else if (reg_wr && ctl_sel) begin
      ctrl_ff <= reg_wdata; // R1
    end
  end

  // Read path; no state gates it, so status is readable in any mode
  always_comb begin
    nxt_rdata = 8'h00;
    nxt_hit = 1'b0;
    if (ctl_sel) begin
      nxt_rdata = ctrl_ff;
      nxt_hit = 1'b1;
    end else if (st_sel) begin
      nxt_rdata = status_word; // R7
      nxt_hit = 1'b1;
    end
  end

  // Writes to the status address fall through the decode untouched
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
      hit_ff <= 1'b0;
    end else begin
      rvalid_ff <= reg_rd;
      if (reg_rd) begin
        rdata_ff <= nxt_rdata; // R17
        hit_ff <= nxt_hit;
      end
    end
  end

  // Idle indication for the receive channel control write window
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_ff <= 1'b0;
    end else begin
      idle_ff <= ~run & core_ready & ~eeprom_eeprom_program_active_run; // R15
    end
  end

  // Receive gating per channel
  genvar gi;
  generate
    for (gi = 0; gi < `GCS_RX_CHANNELS; gi++) begin : g_rx
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          rx_accept_ff[gi] <= 1'b0;
        end else begin
          rx_accept_ff[gi] <= rx_chan_enable[gi] & ctrl_ff.receive_global_enable; // R2 R3
        end
      end
    end
  endgenerate

  // Transmit gating; schedulers held in reset while disabled
  generate
    for (gi = 0; gi < `GCS_TX_CHANNELS; gi++) begin : g_tx
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          tx_send_ff[gi] <= 1'b0;
          tx_rst_ff[gi] <= 1'b1;
        end else begin
          tx_send_ff[gi] <= tx_chan_enable[gi] & ctrl_ff.transmit_global_enable; // R4
          tx_rst_ff[gi] <= ~ctrl_ff.transmit_global_enable; // R5
        end
      end
    end
  endgenerate

  // Label bit mirror for both directions
  generate
    for (gi = 0; gi < `GCS_LABEL_W; gi++) begin : g_rev
      assign rx_rev[gi] = rx_label_in[`GCS_LABEL_W - 1 - gi];
      assign tx_rev[gi] = tx_label_in[`GCS_LABEL_W - 1 - gi];
    end
  endgenerate

  assign nxt_rx_lbl = ctrl_ff.label_bit_reverse ? rx_rev : rx_label_in; // R6
  assign nxt_tx_lbl = ctrl_ff.label_bit_reverse ? tx_rev : tx_label_in; // R6

  // Receive label stage; words dropped while receive is disabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_lbl_ff <= 8'h00;
      rx_lbl_v_ff <= 1'b0;
    end else begin
      rx_lbl_v_ff <= rx_label_valid & ctrl_ff.receive_global_enable; // R3
      if (rx_label_valid) begin
        rx_lbl_ff <= nxt_rx_lbl;
      end
    end
  end

  // Transmit label stage; nothing leaves while transmit is disabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_lbl_ff <= 8'h00;
      tx_lbl_v_ff <= 1'b0;
    end else begin
      tx_lbl_v_ff <= tx_label_valid & ctrl_ff.transmit_global_enable; // R5
      if (tx_label_valid) begin
        tx_lbl_ff <= nxt_tx_lbl;
      end
    end
  end

  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;
  assign reg_hit = hit_ff;
  assign ready = st_bus.ready; // R13
  assign host_idle = idle_ff;
  assign receive_global_enable = ctrl_ff.receive_global_enable;
  assign transmit_global_enable = ctrl_ff.transmit_global_enable;
  assign label_bit_reverse = ctrl_ff.label_bit_reverse;
  assign rx_chan_accept = rx_accept_ff;
  assign tx_chan_send = tx_send_ff;
  assign tx_sched_reset = tx_rst_ff;
  assign rx_label_out = rx_lbl_ff;
  assign rx_label_out_valid = rx_lbl_v_ff;
  assign tx_label_out = tx_lbl_ff;
  assign tx_label_out_valid = tx_lbl_v_ff;
endmodule // gcs_regs

// ---- verif/gcs_host.sv ----
/*
 * Host model driving the register strobes.
 * Assumes one-cycle strobes and a read answer one cycle later.
 */
`timescale 1ns/1ps
module gcs_host (
  input wire logic clk,
  output gcs_pkg::gcs_addr_t reg_addr,
  output logic reg_wr,
  output gcs_pkg::gcs_byte_t reg_wdata,
  output logic reg_rd,
  input wire gcs_pkg::gcs_byte_t reg_rdata,
  input wire logic reg_rvalid
);
  import gcs_pkg::*;
  initial begin
    reg_addr = 16'h0000;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  task automatic wr(input gcs_addr_t a, input gcs_byte_t d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d & 8'hCF;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    // Released bus shows garbage, not the old value
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input gcs_addr_t a, output gcs_byte_t d, output logic v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    v = reg_rvalid;
    d = reg_rdata;
  endtask
endmodule // gcs_host

// ---- verif/gcs_regs_properties.sv ----
/*
 * Port checker for gcs_regs.
 * Assumes one clock and the async active-low reset.
 */
`timescale 1ns/1ps
module gcs_regs_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire gcs_pkg::gcs_addr_t reg_addr,
  input wire logic reg_wr,
  input wire gcs_pkg::gcs_byte_t reg_wdata,
  input wire logic reg_rd,
  input wire gcs_pkg::gcs_byte_t reg_rdata,
  input wire logic reg_rvalid,
  input wire logic reg_hit,
  input wire logic eeprom_eeprom_program_active_run,
  input wire logic ready,
  input wire logic receive_global_enable,
  input wire logic transmit_global_enable,
  input wire logic label_bit_reverse,
  input wire logic [7:0] rx_chan_accept,
  input wire logic [3:0] tx_chan_send,
  input wire logic [3:0] tx_sched_reset,
  input wire gcs_pkg::gcs_label_t rx_label_in,
  input wire logic rx_label_valid,
  input wire gcs_pkg::gcs_label_t rx_label_out,
  input wire logic rx_label_out_valid,
  input wire logic tx_label_valid,
  input wire logic tx_label_out_valid
);
  import gcs_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  function automatic gcs_label_t rv(input gcs_label_t x);
    for (int i = 0; i < 8; i++) rv[i] = x[7 - i];
  endfunction
  sequence s_ctl_wr;
    reg_wr && reg_addr == 16'h800F && !reg_rd;
  endsequence
  sequence s_ctl_rd;
    reg_rd && reg_addr == 16'h800F && !reg_wr;
  endsequence
  chk_rd_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  chk_ctl_apply: assert property (s_ctl_wr |=> {receive_global_enable, transmit_global_enable,
    label_bit_reverse} == {$past(reg_wdata[7]), $past(reg_wdata[6]), $past(reg_wdata[3])})
    else $error("control bits not applied");
  chk_ctl_back: assert property (s_ctl_wr ##1 !reg_wr ##1 s_ctl_rd |=>
    reg_hit && reg_rdata == $past(reg_wdata, 3)) else $error("control readback wrong");
  chk_rx_gate: assert property (!receive_global_enable |=> rx_chan_accept == 8'h00)
    else $error("receive accepted while disabled");
  chk_tx_gate: assert property (!transmit_global_enable |=>
    tx_chan_send == 4'h0 && tx_sched_reset == 4'hF) else $error("transmit not held");
  chk_label_flip: assert property (rx_label_valid && receive_global_enable &&
    label_bit_reverse |=> rx_label_out_valid && rx_label_out == rv($past(rx_label_in)))
    else $error("label not reversed");
  chk_tx_drop: assert property (tx_label_valid && !transmit_global_enable |=> !tx_label_out_valid)
    else $error("transmit label passed while disabled");
  chk_eeprom_program_active_ready: assert property (eeprom_eeprom_program_active_run |=> !ready)
    else $error("ready high while programming");
  chk_status_rd: assert property (reg_rd && reg_addr == 16'h800E |=> reg_hit &&
    reg_rdata[1:0] == 2'b00 && reg_rdata[7] == $past(ready)) else $error("status read wrong");
  chk_unmapped_rd: assert property (reg_rd && reg_addr != 16'h800E && reg_addr != 16'h800F
    |=> !reg_hit && reg_rdata == 8'h00) else $error("unmapped read not zero");
endmodule // gcs_regs_chk
bind gcs_regs gcs_regs_chk i_chk (.clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
  .reg_rdata, .reg_rvalid, .reg_hit, .eeprom_eeprom_program_active_run, .ready, .receive_global_enable,
  .transmit_global_enable, .label_bit_reverse, .rx_chan_accept, .tx_chan_send, .tx_sched_reset,
  .rx_label_in, .rx_label_valid, .rx_label_out, .rx_label_out_valid, .tx_label_valid,
  .tx_label_out_valid);

// ---- verif/global_control_status_regs_test.sv ----
/*
 * Self-checking bench of gcs_regs driven through the host model.
 * Assumes the checker binds itself to the design.
 */
`timescale 1ns/1ps
module global_control_status_regs_test;
  import gcs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] act = 8'h00;
  logic [7:0] rx_chan_enable = 8'h00;
  logic [3:0] tx_chan_enable = 4'h0;
  gcs_label_t rx_label_in = 8'h00;
  gcs_label_t tx_label_in = 8'h00;
  logic rx_label_valid = 1'b0;
  logic tx_label_valid = 1'b0;
  logic [15:0] lfsr = 16'hDA4C;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  logic sf = 1'b0;
  gcs_addr_t reg_addr;
  gcs_byte_t reg_wdata, reg_rdata;
  gcs_label_t rx_label_out, tx_label_out;
  logic reg_wr, reg_rd, reg_rvalid, reg_hit, ready, host_idle, rx_label_out_valid;
  logic receive_global_enable, transmit_global_enable, label_bit_reverse, tx_label_out_valid;
  logic run, core_ready, bist_fail, config_autoload_active_fail, ram_check_run, ram_clear_run;
  logic eeprom_eeprom_program_active_run, autoload_run;
  logic [7:0] rx_chan_accept;
  logic [3:0] tx_chan_send, tx_sched_reset;
  assign {autoload_run, eeprom_eeprom_program_active_run, ram_clear_run, ram_check_run} = act[7:4];
  assign {config_autoload_active_fail, bist_fail, core_ready, run} = act[3:0];
  gcs_regs i_gcs_regs (.clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .reg_rvalid, .reg_hit, .run, .core_ready, .bist_fail, .config_autoload_active_fail, .ram_check_run,
    .ram_clear_run, .eeprom_eeprom_program_active_run, .autoload_run, .ready, .host_idle, .receive_global_enable,
    .transmit_global_enable, .label_bit_reverse, .rx_chan_enable, .rx_chan_accept,
    .tx_chan_enable, .tx_chan_send, .tx_sched_reset, .rx_label_in, .rx_label_valid,
    .rx_label_out, .rx_label_out_valid, .tx_label_in, .tx_label_valid, .tx_label_out,
    .tx_label_out_valid);
  gcs_host i_gcs_host (.clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid);
  always #50 clk = ~clk;
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic gcs_label_t rv(input gcs_label_t x);
    for (int i = 0; i < 8; i++) rv[i] = x[7 - i];
  endfunction
  // Active also needs no fault, no load and no RAM work
  function automatic gcs_byte_t st_exp(input logic [7:0] a, input logic s);
    logic r;
    r = a[1] & ~a[6];
    return {r, a[0] & r & ~s & ~a[2] & ~a[3] & ~a[4] & ~a[5] & ~a[7], s, a[4] | a[5], a[6],
      a[7], 2'b00};
  endfunction
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rdc(input gcs_addr_t a, input gcs_byte_t e, input string n);
    gcs_byte_t d;
    logic v;
    i_gcs_host.rd(a, d, v);
    chk("rvalid", {7'h00, v}, 8'h01);
    chk(n, d, e);
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    act <= 8'h00;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    sf = 1'b0;
  endtask
  task automatic dflt();
    rdc(16'h800E, 8'h00, "status");
    rdc(16'h800F, 8'h00, "control");
    rdc(16'h8010, 8'h00, "unmapped");
    rdc(16'h7FFF, 8'h00, "unmapped");
    chk("sched_reset", {4'h0, tx_sched_reset}, 8'h0F);
    $display("test defaults done");
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      wrap_up();
    end
  end
  initial begin
    gcs_byte_t d;
    gcs_byte_t e;
    do_reset();
    dflt();
    for (int i = 0; i < 16; i++) begin
      lfsr = nx(lfsr);
      d = (i == 0) ? 8'hC8 : (i == 1) ? 8'h00 : lfsr[7:0];
      e = d & 8'hCF;
      i_gcs_host.wr(16'h800F, d);
      rdc(16'h800F, e, "control");
      chk("enables", {5'h00, receive_global_enable, transmit_global_enable, label_bit_reverse},
        {5'h00, e[7], e[6], e[3]});
      @(posedge clk);
      rx_chan_enable <= lfsr[15:8];
      tx_chan_enable <= lfsr[3:0];
      rx_label_in <= lfsr[11:4];
      tx_label_in <= ~lfsr[7:0];
      rx_label_valid <= 1'b1;
      tx_label_valid <= 1'b1;
      @(posedge clk);
      rx_label_valid <= 1'b0;
      tx_label_valid <= 1'b0;
      #1;
      chk("rx_valid", {7'h00, rx_label_out_valid}, {7'h00, e[7]});
      chk("tx_valid", {7'h00, tx_label_out_valid}, {7'h00, e[6]});
      if (e[7]) chk("rx_label", rx_label_out, e[3] ? rv(rx_label_in) : rx_label_in);
      if (e[6]) chk("tx_label", tx_label_out, e[3] ? rv(tx_label_in) : tx_label_in);
      @(posedge clk);
      #1;
      chk("rx_accept", rx_chan_accept, rx_chan_enable & {8{e[7]}});
      chk("tx_send", {4'h0, tx_chan_send}, {4'h0, tx_chan_enable & {4{e[6]}}});
      chk("sched_reset", {4'h0, tx_sched_reset}, {4'h0, {4{~e[6]}}});
    end
    $display("test control done");
    for (int i = 0; i < 22; i++) begin
      lfsr = nx(lfsr);
      d = (i == 0) ? 8'h03 : (i < 20) ? (lfsr[7:0] & 8'hF3) : (i == 20) ? 8'h0A : 8'h03;
      if (d[2] | d[3]) sf = 1'b1;
      @(posedge clk);
      act <= d;
      i_gcs_host.wr(16'h800E, 8'hFF);
      rdc(16'h800E, st_exp(d, sf), "status");
      chk("ready", {7'h00, ready}, {7'h00, d[1] & ~d[6]});
      chk("idle", {7'h00, host_idle}, {7'h00, ~d[0] & d[1] & ~d[6]});
    end
    $display("test status done");
    do_reset();
    dflt();
    // Self-test failure alone must also force safe mode, even with run high
    @(posedge clk);
    act <= 8'h07;
    rdc(16'h800E, st_exp(8'h07, 1'b1), "status");
    $display("test self-test fail done");
    wrap_up();
  end
endmodule // global_control_status_regs_test
